// File: hw/dlc_compare_unit.sv
// One redundancy compare unit with a sticky alarm
`timescale 1ns/10ps
`include "dlc_defines.svh"
module dlc_compare_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             arm,
    input  wire logic [WIDTH-1:0] ref_word,
    input  wire logic [WIDTH-1:0] chk_word,
    input  wire logic             clear,
    output logic                  mismatch_reg,
    output logic                  alarm_reg
);

    logic mismatch_now;
    logic mismatch_next;
    logic alarm_next;

    function automatic logic words_differ(input logic [WIDTH-1:0] a,
                                          input logic [WIDTH-1:0] b);
        return |(a ^ b);
    endfunction

    always_comb begin
        mismatch_now  = arm && words_differ(ref_word, chk_word);
        mismatch_next = mismatch_now;
        alarm_next    = alarm_reg;
        if (clear) begin
            alarm_next = `DLC_ALARM_RESET;
        end
        // Set wins so a mismatch in the clear cycle is kept
        if (mismatch_now) begin
            alarm_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mismatch_reg <= `DLC_ALARM_RESET;
            alarm_reg    <= `DLC_ALARM_RESET;
        end else if (clk_en) begin
            mismatch_reg <= mismatch_next;
            alarm_reg    <= alarm_next;
        end
    end

endmodule

// File: hw/dlc_defines.svh
// Constants for the delayed lockstep checker
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH

// Signal group widths
`define DLC_ADDR_W          32
`define DLC_DATA_W          64
`define DLC_ECC_W           8
`define DLC_CTRL_W          8
`define DLC_RESP_W          8
`define DLC_IRQ_W           8

// Checker trails main by this many clock cycles
`define DLC_LOCKSTEP_DELAY  2
`define DLC_FILL_W          2

// Compare unit indices
`define DLC_UNIT_COUNT      4
`define DLC_UNIT_W          2
`define DLC_UNIT_BUS_REQ    2'h0
`define DLC_UNIT_BUS_WDATA  2'h1
`define DLC_UNIT_LMEM       2'h2
`define DLC_UNIT_DMA        2'h3

// Fault statistics
`define DLC_COUNT_W         8
`define DLC_COUNT_MAX       8'hff

// Reset values
`define DLC_ALARM_RESET     1'b0
`define DLC_UNIT_MASK_RESET 4'h0
`define DLC_COUNT_RESET     8'h00
`define DLC_FILL_RESET      2'h0

`endif

// File: hw/dlc_lockstep_top.sv
// Delayed lockstep checker between the main and checker channels
//
// Function
// - Channel pair seen as one core, main executes
// - Each channel replicates core and bus logic
// - Checker runs two cycles behind main
// - Main outputs delayed before reaching comparators
// - Checker inputs are main inputs, delayed
// - Checker has no direct crossbar connection
// - Checker outputs end only in comparators
// - Every functional channel output is compared
// - Compare unit alarms on any difference
// - Deviation notifies the fault collection unit
// - Mismatch alarm latches until explicit clear
`timescale 1ns/10ps
`include "dlc_defines.svh"
module dlc_lockstep_top (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     clk_en,
    // Main channel outputs, tapped beside their path to the crossbar
    input  wire logic [`DLC_ADDR_W-1:0]   main_bus_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   main_bus_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   main_bus_wdata,
    input  wire logic [`DLC_ECC_W-1:0]    main_bus_wecc,
    input  wire logic [`DLC_ADDR_W-1:0]   main_lmem_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   main_lmem_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   main_lmem_wdata,
    input  wire logic [`DLC_ADDR_W-1:0]   main_dma_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   main_dma_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   main_dma_wdata,
    // Checker channel outputs, terminated here only
    input  wire logic [`DLC_ADDR_W-1:0]   chk_bus_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   chk_bus_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   chk_bus_wdata,
    input  wire logic [`DLC_ECC_W-1:0]    chk_bus_wecc,
    input  wire logic [`DLC_ADDR_W-1:0]   chk_lmem_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   chk_lmem_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   chk_lmem_wdata,
    input  wire logic [`DLC_ADDR_W-1:0]   chk_dma_addr,
    input  wire logic [`DLC_CTRL_W-1:0]   chk_dma_ctrl,
    input  wire logic [`DLC_DATA_W-1:0]   chk_dma_wdata,
    // Inputs as seen by the main channel
    input  wire logic [`DLC_DATA_W-1:0]   main_system_crossbar_rdata,
    input  wire logic [`DLC_ECC_W-1:0]    main_system_crossbar_recc,
    input  wire logic [`DLC_RESP_W-1:0]   main_system_crossbar_resp,
    input  wire logic [`DLC_DATA_W-1:0]   main_lmem_rdata,
    input  wire logic [`DLC_IRQ_W-1:0]    main_irq,
    // Delayed copies fed to the checker channel
    output logic      [`DLC_DATA_W-1:0]   chk_system_crossbar_rdata_reg,
    output logic      [`DLC_ECC_W-1:0]    chk_system_crossbar_recc_reg,
    output logic      [`DLC_RESP_W-1:0]   chk_system_crossbar_resp_reg,
    output logic      [`DLC_DATA_W-1:0]   chk_lmem_rdata_reg,
    output logic      [`DLC_IRQ_W-1:0]    chk_irq_reg,
    // Fault side
    input  wire logic [`DLC_UNIT_COUNT-1:0] fault_clear,
    output logic      [`DLC_UNIT_COUNT-1:0] unit_alarm_reg,
    output logic                          fault_alarm_reg,
    output logic                          fault_event_reg,
    output logic                          first_valid_reg,
    output logic      [`DLC_UNIT_W-1:0]   first_unit_reg,
    output logic      [`DLC_COUNT_W-1:0]  fault_count_reg,
    output logic                          compare_armed_reg
);

    // Delay lines; one array each, indexed by stage
    dlc_pkg::dlc_tap_type    main_pipe_reg  [0:`DLC_LOCKSTEP_DELAY-1];
    dlc_pkg::dlc_tap_type    main_pipe_next [0:`DLC_LOCKSTEP_DELAY-1];
    dlc_pkg::dlc_chk_in_type in_pipe_reg    [0:`DLC_LOCKSTEP_DELAY-1];
    dlc_pkg::dlc_chk_in_type in_pipe_next   [0:`DLC_LOCKSTEP_DELAY-1];

    dlc_pkg::dlc_tap_type    main_tap;
    dlc_pkg::dlc_tap_type    chk_tap;
    dlc_pkg::dlc_tap_type    main_aligned;
    dlc_pkg::dlc_chk_in_type main_in;
    dlc_pkg::dlc_chk_in_type chk_in;

    dlc_pkg::dlc_arm_state_type arm_state_reg;
    dlc_pkg::dlc_arm_state_type arm_state_next;
    logic [`DLC_FILL_W-1:0]     fill_cnt_reg;
    logic [`DLC_FILL_W-1:0]     fill_cnt_next;
    logic                       compare_armed_next;

    logic [`DLC_UNIT_COUNT-1:0] unit_mismatch;
    logic                       fault_alarm_next;
    logic                       fault_event_next;
    logic                       first_valid_next;
    logic [`DLC_UNIT_W-1:0]     first_unit_next;
    logic [`DLC_COUNT_W-1:0]    fault_count_next;

    // Main channel taps; main drives the crossbar itself, this is a copy
    always_comb begin
        main_tap.bus_addr   = main_bus_addr;
        main_tap.bus_ctrl   = main_bus_ctrl;
        main_tap.bus_wdata  = main_bus_wdata;
        main_tap.bus_wecc   = main_bus_wecc;
        main_tap.lmem_addr  = main_lmem_addr;
        main_tap.lmem_ctrl  = main_lmem_ctrl;
        main_tap.lmem_wdata = main_lmem_wdata;
        main_tap.dma_addr   = main_dma_addr;
        main_tap.dma_ctrl   = main_dma_ctrl;
        main_tap.dma_wdata  = main_dma_wdata;
    end

    // Checker outputs go nowhere but the compare units
    always_comb begin
        chk_tap.bus_addr   = chk_bus_addr;
        chk_tap.bus_ctrl   = chk_bus_ctrl;
        chk_tap.bus_wdata  = chk_bus_wdata;
        chk_tap.bus_wecc   = chk_bus_wecc;
        chk_tap.lmem_addr  = chk_lmem_addr;
        chk_tap.lmem_ctrl  = chk_lmem_ctrl;
        chk_tap.lmem_wdata = chk_lmem_wdata;
        chk_tap.dma_addr   = chk_dma_addr;
        chk_tap.dma_ctrl   = chk_dma_ctrl;
        chk_tap.dma_wdata  = chk_dma_wdata;
    end

    // Checker inputs split off the main channel inputs
    always_comb begin
        main_in.system_crossbar_rdata = main_system_crossbar_rdata;
        main_in.system_crossbar_recc  = main_system_crossbar_recc;
        main_in.system_crossbar_resp  = main_system_crossbar_resp;
        main_in.lmem_rdata = main_lmem_rdata;
        main_in.irq        = main_irq;
    end

    // Shift both delay lines by one stage
    always_comb begin
        main_pipe_next[0] = main_tap;
        in_pipe_next[0]   = main_in;
        for (int i = 1; i < `DLC_LOCKSTEP_DELAY; i++) begin
            main_pipe_next[i] = main_pipe_reg[i-1];
            in_pipe_next[i]   = in_pipe_reg[i-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `DLC_LOCKSTEP_DELAY; i++) begin
                main_pipe_reg[i] <= '0;
                in_pipe_reg[i]   <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < `DLC_LOCKSTEP_DELAY; i++) begin
                main_pipe_reg[i] <= main_pipe_next[i];
                in_pipe_reg[i]   <= in_pipe_next[i];
            end
        end
    end

    assign main_aligned = main_pipe_reg[`DLC_LOCKSTEP_DELAY-1];
    assign chk_in       = in_pipe_reg[`DLC_LOCKSTEP_DELAY-1];

    // Replayed inputs; last pipe stage is the output flop
    assign chk_system_crossbar_rdata_reg = chk_in.system_crossbar_rdata;
    assign chk_system_crossbar_recc_reg  = chk_in.system_crossbar_recc;
    assign chk_system_crossbar_resp_reg  = chk_in.system_crossbar_resp;
    assign chk_lmem_rdata_reg = chk_in.lmem_rdata;
    assign chk_irq_reg        = chk_in.irq;

    // Pipes hold reset zeros until filled; comparing then would false alarm
    always_comb begin
        arm_state_next     = arm_state_reg;
        fill_cnt_next      = fill_cnt_reg;
        compare_armed_next = 1'b0;
        unique case (arm_state_reg)
            dlc_pkg::DLC_ARM_FILL: begin
                if (fill_cnt_reg == `DLC_FILL_W'(`DLC_LOCKSTEP_DELAY - 1)) begin
                    arm_state_next     = dlc_pkg::DLC_ARM_LIVE;
                    compare_armed_next = 1'b1;
                end else begin
                    fill_cnt_next = fill_cnt_reg + `DLC_FILL_W'(1);
                end
            end
            dlc_pkg::DLC_ARM_LIVE: begin
                compare_armed_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arm_state_reg     <= dlc_pkg::DLC_ARM_FILL;
            fill_cnt_reg      <= `DLC_FILL_RESET;
            compare_armed_reg <= 1'b0;
        end else if (clk_en) begin
            arm_state_reg     <= arm_state_next;
            fill_cnt_reg      <= fill_cnt_next;
            compare_armed_reg <= compare_armed_next;
        end
    end

    // One compare unit per functional output group
    dlc_compare_unit #(
        .WIDTH (`DLC_ADDR_W + `DLC_CTRL_W)
    ) u_cmp_bus_req (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .arm          (compare_armed_reg),
        .ref_word     ({main_aligned.bus_addr, main_aligned.bus_ctrl}),
        .chk_word     ({chk_tap.bus_addr, chk_tap.bus_ctrl}),
        .clear        (fault_clear[`DLC_UNIT_BUS_REQ]),
        .mismatch_reg (unit_mismatch[`DLC_UNIT_BUS_REQ]),
        .alarm_reg    (unit_alarm_reg[`DLC_UNIT_BUS_REQ])
    );

    dlc_compare_unit #(
        .WIDTH (`DLC_DATA_W + `DLC_ECC_W)
    ) u_cmp_bus_wdata (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .arm          (compare_armed_reg),
        .ref_word     ({main_aligned.bus_wdata, main_aligned.bus_wecc}),
        .chk_word     ({chk_tap.bus_wdata, chk_tap.bus_wecc}),
        .clear        (fault_clear[`DLC_UNIT_BUS_WDATA]),
        .mismatch_reg (unit_mismatch[`DLC_UNIT_BUS_WDATA]),
        .alarm_reg    (unit_alarm_reg[`DLC_UNIT_BUS_WDATA])
    );

    dlc_compare_unit #(
        .WIDTH (`DLC_ADDR_W + `DLC_CTRL_W + `DLC_DATA_W)
    ) u_cmp_lmem (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .arm          (compare_armed_reg),
        .ref_word     ({main_aligned.lmem_addr, main_aligned.lmem_ctrl,
                        main_aligned.lmem_wdata}),
        .chk_word     ({chk_tap.lmem_addr, chk_tap.lmem_ctrl, chk_tap.lmem_wdata}),
        .clear        (fault_clear[`DLC_UNIT_LMEM]),
        .mismatch_reg (unit_mismatch[`DLC_UNIT_LMEM]),
        .alarm_reg    (unit_alarm_reg[`DLC_UNIT_LMEM])
    );

    dlc_compare_unit #(
        .WIDTH (`DLC_ADDR_W + `DLC_CTRL_W + `DLC_DATA_W)
    ) u_cmp_dma (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .arm          (compare_armed_reg),
        .ref_word     ({main_aligned.dma_addr, main_aligned.dma_ctrl,
                        main_aligned.dma_wdata}),
        .chk_word     ({chk_tap.dma_addr, chk_tap.dma_ctrl, chk_tap.dma_wdata}),
        .clear        (fault_clear[`DLC_UNIT_DMA]),
        .mismatch_reg (unit_mismatch[`DLC_UNIT_DMA]),
        .alarm_reg    (unit_alarm_reg[`DLC_UNIT_DMA])
    );

    // Notification toward the fault collection unit
    always_comb begin
        fault_alarm_next = |unit_alarm_reg;
        fault_event_next = |unit_mismatch;
        first_valid_next = first_valid_reg;
        first_unit_next  = first_unit_reg;
        fault_count_next = fault_count_reg;
        if (first_valid_reg && fault_clear[first_unit_reg]) begin
            first_valid_next = 1'b0;
            fault_count_next = `DLC_COUNT_RESET;
        end
        // Lowest index wins when several units trip together
        if (!first_valid_next && |unit_mismatch) begin
            first_valid_next = 1'b1;
            for (int u = `DLC_UNIT_COUNT - 1; u >= 0; u--) begin
                if (unit_mismatch[u]) begin
                    first_unit_next = `DLC_UNIT_W'(u);
                end
            end
        end
        // Counts cycles with a mismatch, saturating
        if (|unit_mismatch && fault_count_next != `DLC_COUNT_MAX) begin
            fault_count_next = fault_count_next + `DLC_COUNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_alarm_reg <= `DLC_ALARM_RESET;
            fault_event_reg <= 1'b0;
            first_valid_reg <= 1'b0;
            first_unit_reg  <= `DLC_UNIT_BUS_REQ;
            fault_count_reg <= `DLC_COUNT_RESET;
        end else if (clk_en) begin
            fault_alarm_reg <= fault_alarm_next;
            fault_event_reg <= fault_event_next;
            first_valid_reg <= first_valid_next;
            first_unit_reg  <= first_unit_next;
            fault_count_reg <= fault_count_next;
        end
    end

endmodule

// File: hw/dlc_pkg.sv
// Types shared by the delayed lockstep checker
package dlc_pkg;

    // Functional outputs of one channel toward the rest of the chip
    typedef struct packed {
        logic [31:0] bus_addr;
        logic [7:0]  bus_ctrl;
        logic [63:0] bus_wdata;
        logic [7:0]  bus_wecc;
        logic [31:0] lmem_addr;
        logic [7:0]  lmem_ctrl;
        logic [63:0] lmem_wdata;
        logic [31:0] dma_addr;
        logic [7:0]  dma_ctrl;
        logic [63:0] dma_wdata;
    } dlc_tap_type;

    // Inputs split off from main and replayed to the checker
    typedef struct packed {
        logic [63:0] system_crossbar_rdata;
        logic [7:0]  system_crossbar_recc;
        logic [7:0]  system_crossbar_resp;
        logic [63:0] lmem_rdata;
        logic [7:0]  irq;
    } dlc_chk_in_type;

    typedef enum logic {
        DLC_ARM_FILL,
        DLC_ARM_LIVE
    } dlc_arm_state_type;

endpackage

// File: sim/dlc_far_model.sv
// Crossbar and fault collector model at the far side
`timescale 1ns/10ps
module dlc_far_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  clr_req,
    input  wire logic        fault_event_reg,
    output logic      [63:0] main_system_crossbar_rdata,
    output logic      [7:0]  main_system_crossbar_recc,
    output logic      [7:0]  main_system_crossbar_resp,
    output logic      [63:0] main_lmem_rdata,
    output logic      [7:0]  main_irq,
    output logic      [3:0]  fault_clear,
    output int               event_cnt
);
    // Fresh data every cycle so a stuck replay stage shows up
    initial begin
        {main_system_crossbar_rdata, main_system_crossbar_recc, main_system_crossbar_resp} = '0;
        {main_lmem_rdata, main_irq} = '0;
        forever begin
            @(negedge ref_clk);
            main_system_crossbar_rdata = {$urandom, $urandom};
            main_system_crossbar_recc = 8'($urandom);
            main_system_crossbar_resp = 8'($urandom);
            main_lmem_rdata = {$urandom, $urandom};
            main_irq = 8'($urandom);
        end
    end
    always @(posedge ref_clk) begin
        if (fault_event_reg === 1'b1) begin
            event_cnt <= event_cnt + 1;
        end
    end
    assign fault_clear = clr_req;
endmodule

// File: sim/dlc_lockstep_props.sv
// Port assertions for the delayed lockstep checker
`timescale 1ns/10ps
`include "dlc_defines.svh"
module dlc_lockstep_props (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       clk_en,
    input wire logic [`DLC_ADDR_W-1:0]     main_bus_addr,
    input wire logic [`DLC_CTRL_W-1:0]     main_bus_ctrl,
    input wire logic [`DLC_DATA_W-1:0]     main_bus_wdata,
    input wire logic [`DLC_ECC_W-1:0]      main_bus_wecc,
    input wire logic [`DLC_ADDR_W-1:0]     chk_bus_addr,
    input wire logic [`DLC_CTRL_W-1:0]     chk_bus_ctrl,
    input wire logic [`DLC_DATA_W-1:0]     chk_bus_wdata,
    input wire logic [`DLC_ECC_W-1:0]      chk_bus_wecc,
    input wire logic [`DLC_DATA_W-1:0]     main_system_crossbar_rdata,
    input wire logic [`DLC_IRQ_W-1:0]      main_irq,
    input wire logic [`DLC_DATA_W-1:0]     chk_system_crossbar_rdata_reg,
    input wire logic [`DLC_IRQ_W-1:0]      chk_irq_reg,
    input wire logic [`DLC_UNIT_COUNT-1:0] fault_clear,
    input wire logic [`DLC_UNIT_COUNT-1:0] unit_alarm_reg,
    input wire logic                       fault_alarm_reg,
    input wire logic                       fault_event_reg,
    input wire logic [`DLC_COUNT_W-1:0]    fault_count_reg,
    input wire logic                       compare_armed_reg
);
    logic [1:0] en_hist_reg;
    logic [1:0] en_hist_next;
    logic       ok3;
    // Delayed compares are only valid behind two clean enabled edges
    always_comb begin
        en_hist_next = {en_hist_reg[0], clk_en & rst_n};
    end
    always_ff @(posedge ref_clk) begin
        en_hist_reg <= en_hist_next;
    end
    assign ok3 = clk_en & (en_hist_reg == 2'b11);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    reset_clear_a: assert property (
        !$past(rst_n) |-> (unit_alarm_reg == 4'h0) && !fault_alarm_reg && !compare_armed_reg
        && (fault_count_reg == 8'h00)) else $error("Outputs not cleared by reset");
    arm_delay_a: assert property (
        $rose(rst_n) && clk_en ##1 clk_en |-> !compare_armed_reg ##1 compare_armed_reg)
        else $error("Compare not armed after fill");
    replay_a: assert property (
        en_hist_reg == 2'b11 |-> {chk_irq_reg, chk_system_crossbar_rdata_reg}
        == $past({main_irq, main_system_crossbar_rdata}, 2)) else $error("Checker input not replayed");
    bus_req_a: assert property (
        ok3 && compare_armed_reg && ({chk_bus_addr, chk_bus_ctrl}
        != $past({main_bus_addr, main_bus_ctrl}, 2)) |=> unit_alarm_reg[0])
        else $error("Request mismatch not flagged");
    bus_wdata_a: assert property (
        ok3 && compare_armed_reg && ({chk_bus_wdata, chk_bus_wecc}
        != $past({main_bus_wdata, main_bus_wecc}, 2)) |=> unit_alarm_reg[1])
        else $error("Write data mismatch not flagged");
    sticky_alarm_a: assert property (
        (unit_alarm_reg & ~fault_clear) != 4'h0
        |=> ($past(unit_alarm_reg & ~fault_clear) & ~unit_alarm_reg) == 4'h0)
        else $error("Alarm dropped without clear");
    alarm_or_a: assert property (
        $past(clk_en) && $past(rst_n) |-> fault_alarm_reg == |$past(unit_alarm_reg))
        else $error("Fault alarm not the unit summary");
    event_cause_a: assert property (
        fault_event_reg |-> $past(unit_alarm_reg) != 4'h0)
        else $error("Fault event without alarm");

    cover property (unit_alarm_reg[0]);
    cover property ((fault_clear != 4'h0) && (unit_alarm_reg != 4'h0));
    cover property (fault_count_reg == 8'hff);
endmodule

// File: sim/tb_delayed_lockstep_checker.sv
// Self-checking bench for the delayed lockstep checker
`timescale 1ns/10ps
`include "dlc_defines.svh"
module tb_delayed_lockstep_checker;
    logic                 ref_clk, rst_n, clk_en, first_valid_reg, compare_armed_reg;
    logic                 fault_alarm_reg, fault_event_reg;
    logic [3:0]           clr_req, fault_clear, unit_alarm_reg;
    logic [1:0]           first_unit_reg;
    logic [7:0]           fault_count_reg, chk_system_crossbar_recc_reg, chk_system_crossbar_resp_reg, chk_irq_reg;
    logic [7:0]           main_system_crossbar_recc, main_system_crossbar_resp, main_irq;
    logic [63:0]          main_system_crossbar_rdata, main_lmem_rdata, chk_system_crossbar_rdata_reg, chk_lmem_rdata_reg;
    logic [151:0]         in_h1, in_h2;
    dlc_pkg::dlc_tap_type m0, m1, m2, chk;
    int                   n_errors, n_tests, cyc, ev, ev0;
    bit                   chk_on;

    dlc_far_model far (.ref_clk(ref_clk), .clr_req(clr_req), .fault_event_reg(fault_event_reg),
        .main_system_crossbar_rdata(main_system_crossbar_rdata), .main_system_crossbar_recc(main_system_crossbar_recc),
        .main_system_crossbar_resp(main_system_crossbar_resp), .main_lmem_rdata(main_lmem_rdata),
        .main_irq(main_irq), .fault_clear(fault_clear), .event_cnt(ev));
    dlc_lockstep_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .main_bus_addr(m0.bus_addr), .main_bus_ctrl(m0.bus_ctrl), .main_bus_wdata(m0.bus_wdata),
        .main_bus_wecc(m0.bus_wecc), .main_lmem_addr(m0.lmem_addr), .main_lmem_ctrl(m0.lmem_ctrl),
        .main_lmem_wdata(m0.lmem_wdata), .main_dma_addr(m0.dma_addr), .main_dma_ctrl(m0.dma_ctrl),
        .main_dma_wdata(m0.dma_wdata), .chk_bus_addr(chk.bus_addr), .chk_bus_ctrl(chk.bus_ctrl),
        .chk_bus_wdata(chk.bus_wdata), .chk_bus_wecc(chk.bus_wecc),
        .chk_lmem_addr(chk.lmem_addr), .chk_lmem_ctrl(chk.lmem_ctrl),
        .chk_lmem_wdata(chk.lmem_wdata), .chk_dma_addr(chk.dma_addr),
        .chk_dma_ctrl(chk.dma_ctrl), .chk_dma_wdata(chk.dma_wdata),
        .main_system_crossbar_rdata(main_system_crossbar_rdata), .main_system_crossbar_recc(main_system_crossbar_recc),
        .main_system_crossbar_resp(main_system_crossbar_resp), .main_lmem_rdata(main_lmem_rdata), .main_irq(main_irq),
        .chk_system_crossbar_rdata_reg(chk_system_crossbar_rdata_reg), .chk_system_crossbar_recc_reg(chk_system_crossbar_recc_reg),
        .chk_system_crossbar_resp_reg(chk_system_crossbar_resp_reg), .chk_lmem_rdata_reg(chk_lmem_rdata_reg),
        .chk_irq_reg(chk_irq_reg), .fault_clear(fault_clear), .unit_alarm_reg(unit_alarm_reg),
        .fault_alarm_reg(fault_alarm_reg), .fault_event_reg(fault_event_reg),
        .first_valid_reg(first_valid_reg), .first_unit_reg(first_unit_reg),
        .fault_count_reg(fault_count_reg), .compare_armed_reg(compare_armed_reg));

    task automatic check(input string what, input logic [151:0] exp, input logic [151:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One bit flipped in a field that belongs to compare unit u
    function automatic dlc_pkg::dlc_tap_type flip(input int u, input int unsigned r);
        dlc_pkg::dlc_tap_type t;
        t = '0;
        case (u)
            0: t.bus_addr[r % 32] = 1'b1;
            1: t.bus_wecc[r % 8] = 1'b1;
            2: t.lmem_wdata[r % 64] = 1'b1;
            default: t.dma_ctrl[r % 8] = 1'b1;
        endcase
        return t;
    endfunction

    // Checker channel replays main two cycles late; now=1 drops the lag
    task automatic step(input dlc_pkg::dlc_tap_type err, input bit now);
        logic [319:0] rnd;
        @(negedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            rnd = {rnd[287:0], $urandom};
        end
        m2 = m1;
        m1 = m0;
        m0 = rnd;
        chk = (now ? m0 : m2) ^ err;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        in_h2 <= in_h1;
        in_h1 <= {main_system_crossbar_rdata, main_system_crossbar_recc, main_system_crossbar_resp, main_lmem_rdata, main_irq};
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            give_verdict();
        end
    end

    always @(negedge ref_clk) begin
        if (chk_on) begin
            check("replay", in_h2, {chk_system_crossbar_rdata_reg, chk_system_crossbar_recc_reg, chk_system_crossbar_resp_reg,
                chk_lmem_rdata_reg, chk_irq_reg});
        end
    end

    initial begin
        void'($urandom(32'h493d));
        {rst_n, chk_on, n_errors, n_tests} = '0;
        {m0, m1, m2, chk, clr_req} = '0;
        clk_en = 1'b1;
        repeat (2) step('0, 1'b0);
        check("reset_out", 0, {unit_alarm_reg, fault_alarm_reg, first_valid_reg,
            compare_armed_reg, fault_count_reg});
        rst_n = 1'b1;
        // Mismatch during fill must not count
        step(flip(0, $urandom), 1'b0);
        check("armed_early", 0, compare_armed_reg);
        repeat (2) step('0, 1'b0);
        check("armed", 1, compare_armed_reg);
        chk_on = 1'b1;
        repeat (150) step('0, 1'b0);
        check("clean", 0, {unit_alarm_reg, fault_count_reg});
        for (int u = 0; u < 4; u++) begin
            ev0 = ev;
            step(flip(u, $urandom), 1'b0);
            step('0, 1'b0);
            check("unit_alarm", 4'h1 << u, unit_alarm_reg);
            step('0, 1'b0);
            check("fault_alarm", 3'b111, {fault_event_reg, fault_alarm_reg, first_valid_reg});
            check("first_unit", u, first_unit_reg);
            check("count", 1, fault_count_reg);
            repeat (5) step('0, 1'b0);
            check("sticky", 4'h1 << u, {fault_event_reg, unit_alarm_reg});
            check("notified", 1, ev - ev0);
            clr_req = 4'h1 << u;
            step('0, 1'b0);
            clr_req = 4'h0;
            check("cleared", 0, {unit_alarm_reg, first_valid_reg, fault_count_reg});
            step('0, 1'b0);
            check("alarm_off", 0, fault_alarm_reg);
        end
        // Without the lag every unit differs; lowest unit recorded
        step('0, 1'b1);
        step('0, 1'b0);
        check("no_lag", 4'hf, unit_alarm_reg);
        step('0, 1'b0);
        check("first_low", 3'b100, {first_valid_reg, first_unit_reg});
        clr_req = 4'h2;
        step('0, 1'b0);
        check("other_kept", 4'hd, unit_alarm_reg);
        // Clear in the mismatching cycle loses
        step(flip(1, $urandom), 1'b0);
        step('0, 1'b0);
        check("set_wins", 4'hf, unit_alarm_reg);
        clr_req = 4'hf;
        step('0, 1'b0);
        clr_req = 4'h0;
        check("all_clear", 0, unit_alarm_reg);
        repeat (260) step(flip(2, $urandom), 1'b0);
        step('0, 1'b0);
        check("saturate", 8'hff, fault_count_reg);
        chk_on = 1'b0;
        rst_n = 1'b0;
        repeat (2) step('0, 1'b0);
        rst_n = 1'b1;
        step('0, 1'b0);
        check("reset_alarm", 0, {unit_alarm_reg, fault_alarm_reg, fault_count_reg});
        give_verdict();
    end
endmodule

bind dlc_lockstep_top dlc_lockstep_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .main_bus_addr(main_bus_addr), .main_bus_ctrl(main_bus_ctrl),
    .main_bus_wdata(main_bus_wdata), .main_bus_wecc(main_bus_wecc),
    .chk_bus_addr(chk_bus_addr), .chk_bus_ctrl(chk_bus_ctrl), .chk_bus_wdata(chk_bus_wdata),
    .chk_bus_wecc(chk_bus_wecc), .main_system_crossbar_rdata(main_system_crossbar_rdata), .main_irq(main_irq),
    .chk_system_crossbar_rdata_reg(chk_system_crossbar_rdata_reg), .chk_irq_reg(chk_irq_reg),
    .fault_clear(fault_clear), .unit_alarm_reg(unit_alarm_reg),
    .fault_alarm_reg(fault_alarm_reg), .fault_event_reg(fault_event_reg),
    .fault_count_reg(fault_count_reg), .compare_armed_reg(compare_armed_reg));
